// >>> core/sipo_fifo.sv
// Small valid/ready FIFO carrying parallel words from shift register to storage register.
`timescale 1ns/100ps
module sipo_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset.
   input  wire logic             i_clock,
   input  wire logic             i_reset_n,
   // Fill side.
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Drain side.
   output logic                  o_out_valid,
   output logic      [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready,
   // Flush, tied low by sipo_latch; the clear pin does not use it.
   input  wire logic             i_flush
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];
   assign push        = i_in_valid && o_in_ready && !i_flush;
   assign pop         = o_out_valid && i_out_ready && !i_flush;

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else if (i_flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_r + 1'b1);
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_r + 1'b1);
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // sipo_fifo

// >>> core/sipo_latch.sv
// Serial-in, parallel-out shift register with storage register and gated open-drain outputs.
`timescale 1ns/100ps
module sipo_latch
   import sipo_pkg::*;
(
   // Clock and reset.
   input  wire logic                     i_clock,
   input  wire logic                     i_reset_n,
   // Host pins, asynchronous to i_clock.
   input  wire logic                     i_shift_clock,
   input  wire logic                     i_storage_load_clock,
   input  wire logic                     i_serial_in,
   input  wire logic                     i_shift_clear_n,
   input  wire logic                     i_output_enable_n,
   // Cascade output.
   output logic                          o_serial_cascade_out,
   // Open-drain drain stages.
   output logic [SIPO_WIDTH-1:0]         o_drain_out,
   output logic [SIPO_WIDTH-1:0]         o_drain_oe_n,
   // Parallel view of the output buffer.
   output logic [SIPO_WIDTH-1:0]         o_output_buffer
);
   import sipo_pkg::*;

   localparam int unsigned          PIN_COUNT = $bits(sipo_pins_type);
   localparam int unsigned          SYNC_MSB  = SIPO_SYNC_LEN - 1;
   localparam logic [PIN_COUNT-1:0] PIN_IDLE  = SIPO_PIN_IDLE;

   // Latency from a host pin edge, counted in system clock edges: the first
   // three fill the sampler and the fourth moves the filtered level. A shift
   // clock rise moves the shifter and the cascade on the fourth edge. A load
   // rise enters the FIFO on the fourth edge, reaches storage on the fifth and
   // the buffer and drains on the sixth. An enable change reaches the buffer
   // and drains on the fifth edge. Pulses shorter than two system clocks may be
   // missed; that is the price of never acting on a single-cycle glitch.
   sipo_pins_type            raw;
   sipo_pins_type            pins;
   sipo_pins_type            rise;
   logic [PIN_COUNT-1:0]     raw_bits;
   logic [PIN_COUNT-1:0]     level_bits;
   logic [PIN_COUNT-1:0]     rise_bits;
   logic [SIPO_WIDTH-1:0]    shift_r;
   logic [SIPO_WIDTH-1:0]    store_r;
   logic                     cascade_r;
   sipo_drain_type           drain_r;
   logic [SIPO_WIDTH-1:0]    buffer_r;
   logic                     shift_rise;
   logic                     load_rise;
   logic                     fifo_in_ready;
   logic                     fifo_out_valid;
   logic [SIPO_WIDTH-1:0]    fifo_out_data;
   logic [SIPO_WIDTH-1:0]    buffer_nxt;

   assign raw = '{shift_clock:        i_shift_clock,
                  storage_load_clock: i_storage_load_clock,
                  serial_in:          i_serial_in,
                  shift_clear_n:      i_shift_clear_n,
                  output_enable_n:    i_output_enable_n};
   assign raw_bits = raw;

   // One sampler per pin. Stage zero is read only by stage one, and the level
   // moves once stages one and two agree, so a one-cycle glitch never counts.
   for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
      logic [SYNC_MSB:0] stage_r;
      logic              level_r;

      always_ff @(posedge i_clock or negedge i_reset_n) begin
         if (!i_reset_n) begin
            stage_r <= {SIPO_SYNC_LEN{PIN_IDLE[g]}};
         end else begin
            stage_r <= {stage_r[SYNC_MSB-1:0], raw_bits[g]};
         end
      end

      always_ff @(posedge i_clock or negedge i_reset_n) begin
         if (!i_reset_n) begin
            level_r <= PIN_IDLE[g];
         end else if (stage_r[SYNC_MSB] == stage_r[SYNC_MSB-1]) begin
            level_r <= stage_r[SYNC_MSB];
         end
      end

      assign level_bits[g] = level_r;
      assign rise_bits[g]  = stage_r[SYNC_MSB] && stage_r[SYNC_MSB-1] && !level_r;
   end

   assign pins = sipo_pins_type'(level_bits);
   assign rise = sipo_pins_type'(rise_bits);

   // Each clock pin has its own sampler, so the host may drive them independently.
   assign shift_rise = rise.shift_clock;
   assign load_rise  = rise.storage_load_clock;

   // Shift register; the clear wins over a shift clock edge in the same cycle.
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shift_r <= SIPO_SHIFT_RST;
      end else if (!pins.shift_clear_n) begin
         shift_r <= SIPO_SHIFT_RST;
      end else if (shift_rise) begin
         shift_r <= {shift_r[SIPO_WIDTH-2:0], pins.serial_in};
      end
   end

   // Cascade output shows the bit leaving the last stage. Clearing does not
   // touch it, since it only moves on a shift clock rise.
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cascade_r <= 1'b0;
      end else if (shift_rise && pins.shift_clear_n) begin
         cascade_r <= shift_r[SIPO_LAST_BIT];
      end
   end

   // The load snapshot goes through the FIFO. Its drain never stalls, so one
   // word passes per cycle; a full FIFO would only arise from back-to-back
   // loads faster than the pins can toggle, which the synchroniser excludes.
   sipo_fifo #(
      .WIDTH (SIPO_WIDTH),
      .DEPTH (SIPO_FIFO_DEPTH)
   ) u_fifo (
      .i_clock     (i_clock),
      .i_reset_n   (i_reset_n),
      .i_in_valid  (load_rise),
      .i_in_data   (shift_r),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (fifo_out_valid),
      .o_out_data  (fifo_out_data),
      .i_out_ready (1'b1),
      .i_flush     (1'b0)
   );

   // Storage register takes all eight bits at once and holds them.
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         store_r <= SIPO_STORE_RST;
      end else if (fifo_out_valid && fifo_in_ready) begin
         store_r <= fifo_out_data;
      end else if (fifo_out_valid) begin
         store_r <= fifo_out_data;
      end
   end

   // Output gate: disabled forces every buffer bit low.
   always_comb begin
      if (pins.output_enable_n) begin
         buffer_nxt = '0;
      end else begin
         buffer_nxt = store_r;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         buffer_r <= SIPO_BUFFER_RST;
      end else begin
         buffer_r <= buffer_nxt;
      end
   end

   // A high buffer bit turns its drain on: it drives low with enable low.
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         drain_r <= SIPO_DRAIN_RST;
      end else begin
         drain_r.drain_out  <= '0;
         drain_r.drain_oe_n <= ~buffer_nxt;
      end
   end

   assign o_serial_cascade_out = cascade_r;
   assign o_drain_out          = drain_r.drain_out;
   assign o_drain_oe_n         = drain_r.drain_oe_n;
   assign o_output_buffer      = buffer_r;
endmodule // sipo_latch

// >>> core/sipo_pkg.sv
// Package with the shared constants and carrier types of the serial-in latch block.
package sipo_pkg;
   localparam int unsigned SIPO_WIDTH      = 8;
   localparam int unsigned SIPO_FIFO_DEPTH = 4;
   localparam int unsigned SIPO_SYNC_LEN   = 3;
   localparam logic [7:0]  SIPO_SHIFT_RST  = 8'h00;
   localparam logic [7:0]  SIPO_STORE_RST  = 8'h00;
   localparam int unsigned SIPO_LAST_BIT   = 7;

   // Synchronised view of the host pins.
   typedef struct packed {
      logic shift_clock;
      logic storage_load_clock;
      logic serial_in;
      logic shift_clear_n;
      logic output_enable_n;
   } sipo_pins_type;

   // Open-drain drain outputs: enable low means the stage sinks current.
   typedef struct packed {
      logic [7:0] drain_out;
      logic [7:0] drain_oe_n;
   } sipo_drain_type;

   // Idle levels of the host pins, so that leaving reset shows no false edge.
   localparam sipo_pins_type  SIPO_PIN_IDLE   = '{default: 1'b0, shift_clear_n: 1'b1, output_enable_n: 1'b1};
   localparam logic [7:0]     SIPO_BUFFER_RST = 8'h00;
   localparam sipo_drain_type SIPO_DRAIN_RST  = '{drain_out: 8'h00, drain_oe_n: 8'hff};
endpackage

// >>> verification/sipo_host_model.sv
// Host controller model driving the shift and load clocks and serial data.
`timescale 1ns/100ps
module sipo_host_model (
   // System clock used only to pace the pins.
   input  wire logic i_clock,
   // Host pins.
   output logic      o_shift_clock,
   output logic      o_storage_load_clock,
   output logic      o_serial_in
);
   initial begin
      o_shift_clock = 1'b0;
      o_storage_load_clock = 1'b0;
      o_serial_in = 1'b0;
   end
   // Four cycles per phase gives the 160 ns link period; the clock stands low between frames.
   task automatic hold4;
      repeat (4) @(negedge i_clock);
   endtask
   task automatic shift_bit(input logic b);
      o_serial_in = b;
      hold4();
      o_shift_clock = 1'b1;
      repeat (2) @(negedge i_clock);
      o_serial_in = ~b; // The hold has run out, so the line no longer shows the bit.
      repeat (2) @(negedge i_clock);
      o_shift_clock = 1'b0;
   endtask
   task automatic load;
      o_storage_load_clock = 1'b1;
      hold4();
      o_storage_load_clock = 1'b0;
      hold4();
   endtask
endmodule // sipo_host_model

// >>> verification/sipo_latch_sva.sv
// Port-level assertions for the serial-in latch.
`timescale 1ns/100ps
module sipo_latch_sva
   import sipo_pkg::*;
(
   // Clock and reset.
   input wire logic                  i_clock,
   input wire logic                  i_reset_n,
   // Host pins.
   input wire logic                  i_shift_clock,
   input wire logic                  i_storage_load_clock,
   input wire logic                  i_shift_clear_n,
   input wire logic                  i_output_enable_n,
   // Outputs.
   input wire logic                  o_serial_cascade_out,
   input wire logic [SIPO_WIDTH-1:0] o_drain_out,
   input wire logic [SIPO_WIDTH-1:0] o_drain_oe_n,
   input wire logic [SIPO_WIDTH-1:0] o_output_buffer
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   // Pins pass a three-stage sampler, so every output trails its cause by a fixed count.
   sequence s_oe_off;
      $rose(i_output_enable_n) ##1 i_output_enable_n [*4];
   endsequence
   sequence s_load_idle;
      (!i_storage_load_clock && $stable(i_output_enable_n)) [*8];
   endsequence
   a_oe_gates_buf: assert property (s_oe_off |=> o_output_buffer == 8'h00)
      else $error("buffer not gated");
   a_buf_needs_oe: assert property (o_output_buffer != 8'h00 |-> !$past(i_output_enable_n, 5))
      else $error("buffer shown while disabled");
   a_drain_map: assert property (o_drain_oe_n == ~o_output_buffer)
      else $error("drain enable mismatch");
   a_drain_low: assert property (o_drain_out == 8'h00)
      else $error("drain level not low");
   a_cascade_edge: assert property ($changed(o_serial_cascade_out) |-> $past(i_shift_clock, 4) && !$past(i_shift_clock, 5))
      else $error("cascade moved off a shift rise");
   a_clear_blocks: assert property (!i_shift_clear_n [*8] |=> $stable(o_serial_cascade_out))
      else $error("shift during clear");
   a_store_hold: assert property (s_load_idle |=> $stable(o_output_buffer))
      else $error("storage changed without load");
endmodule // sipo_latch_sva

bind sipo_latch sipo_latch_sva u_sva (
   .i_clock, .i_reset_n, .i_shift_clock, .i_storage_load_clock, .i_shift_clear_n, .i_output_enable_n,
   .o_serial_cascade_out, .o_drain_out, .o_drain_oe_n, .o_output_buffer
);

// >>> verification/tb_top.sv
// Self-checking bench for the serial-in latch.
`timescale 1ns/100ps
module tb_top;
   logic       clk, rst_n, shift_clock, load_clock, serial_in, clear_n, oe_n, cascade;
   logic [7:0] drain_out, drain_oe_n, buffer;
   int         err_total, num_checks;
   sipo_latch dut (.i_clock(clk), .i_reset_n(rst_n), .i_shift_clock(shift_clock), .i_storage_load_clock(load_clock),
      .i_serial_in(serial_in), .i_shift_clear_n(clear_n), .i_output_enable_n(oe_n), .o_serial_cascade_out(cascade),
      .o_drain_out(drain_out), .o_drain_oe_n(drain_oe_n), .o_output_buffer(buffer));
   sipo_host_model host (.i_clock(clk), .o_shift_clock(shift_clock), .o_storage_load_clock(load_clock),
      .o_serial_in(serial_in));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("Error at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   // Each shift pushes out the old last stage, so prev is read from its top bit down.
   task automatic shift_word(input logic [7:0] w, input logic [7:0] prev);
      for (int i = 7; i >= 0; i--) begin
         host.shift_bit(w[i]);
         check({7'h00, cascade}, {7'h00, prev[i]});
      end
   endtask
   task automatic wait6;
      repeat (6) @(negedge clk);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      check(buffer, 8'h00);
      check(drain_oe_n, 8'hff);
      check(drain_out, 8'h00);
      check({7'h00, cascade}, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_load;
      oe_n = 1'b0;
      shift_word(8'ha5, 8'h00);
      shift_word(8'h3c, 8'ha5);
      host.load();
      check(buffer, 8'h3c);
      check(drain_oe_n, 8'hc3);
      shift_word(8'hff, 8'h3c);
      check(buffer, 8'h3c);
      $display("load test done");
   endtask
   task automatic t_gate;
      oe_n = 1'b1;
      wait6();
      check(buffer, 8'h00);
      check(drain_oe_n, 8'hff);
      oe_n = 1'b0;
      wait6();
      check(buffer, 8'h3c);
      check(drain_oe_n, 8'hc3);
      $display("gate test done");
   endtask
   task automatic t_clear;
      // A high cascade before the clear makes a blocked shift visible.
      host.shift_bit(1'b0);
      check({7'h00, cascade}, 8'h01);
      clear_n = 1'b0;
      wait6();
      shift_word(8'hff, 8'hff);
      check(buffer, 8'h3c);
      clear_n = 1'b1;
      wait6();
      host.load();
      check(buffer, 8'h00);
      $display("clear test done");
   endtask
   initial begin
      rst_n = 1'b0;
      clear_n = 1'b1;
      oe_n = 1'b1;
      err_total = 0;
      num_checks = 0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_load();
      t_gate();
      t_clear();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      summarize();
   end
endmodule // tb_top
